// >>> rtl/synth_loader_pkg.sv
// Purpose: Constants for the dual synthesizer serial control loader.
// Assumes: Serial pins are asynchronous to clk and sampled by it.
// Notes: Field positions below are bit indices inside the 22-bit word.
package synth_loader_pkg;
   localparam int WORD_W = 22;
   localparam int NUM_REGS = 4;
   localparam int CTRL_W = 2;
   localparam logic [WORD_W-1:0] WORD_RESET = 22'h000000;
   // Field positions inside the 22-bit word (above the two control bits).
   localparam int F_PRESCALE = 2;
   localparam int F_PWDN = 3;
   localparam int F_PWDN_MODE = 4;
   localparam int F_PUMP_TRI = 5;
   localparam int F_PUMP_CUR = 6;
   localparam int F_FAST = 7;
   localparam int F_MUX_LO = 8;
   localparam int MUX_W = 3;
   // Register indices selected by the control bits.
   localparam logic [1:0] SEL_FIRST = 2'h0;
   localparam logic [1:0] SEL_SECOND = 2'h1;
   localparam logic [1:0] SEL_MUX = 2'h2;
   // Status pin functions.
   localparam logic [2:0] MUX_TRI = 3'h0;
   localparam logic [2:0] MUX_GP_LOW = 3'h1;
   localparam logic [2:0] MUX_GP_HIGH = 3'h2;
   localparam logic [2:0] MUX_LOCK_FIRST = 3'h3;
   localparam logic [2:0] MUX_LOCK_SECOND = 3'h4;
   localparam logic [2:0] MUX_REF_DIV = 3'h5;
   localparam logic [2:0] MUX_FB_DIV = 3'h6;
   localparam logic [2:0] MUX_FAST_SW = 3'h7;
endpackage

// >>> rtl/synth_loader.sv
// Purpose: Serial loader for the control state of a dual RF synthesizer.
// Assumes: serial_clk, serial_data and load_strobe come from another clock domain.
// Notes: Analog parts are outside; this block only presents control levels.
`timescale 1ns/10ps
module synth_loader
   import synth_loader_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic lock_first,
   input wire logic lock_second,
   input wire logic ref_div_out,
   input wire logic fb_div_out,
   output logic mux_status_out,
   output logic mux_status_oe,
   output logic prescale_128_first,
   output logic prescale_128_second,
   output logic pwdn_first,
   output logic pwdn_second,
   output logic pwdn_async,
   output logic pump_tri,
   output logic pump_hi_cur_first,
   output logic pump_hi_cur_second,
   output logic fast_acq_first,
   output logic [WORD_W-1:0] shift_word
);
   // ==========================================================
   // Input synchronisers
   // Three flops per pin; the edge detector compares the second and third stages.
   logic [2:0] sync1_reg, sync2_reg, sync3_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
      end else begin
         sync1_reg <= {serial_clk, serial_data, load_strobe};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   logic sck_rise, strobe_rise, sdata;
   assign sck_rise = sync2_reg[2] & ~sync3_reg[2];
   // Data is taken from the same delayed stage so setup margin is kept.
   assign sdata = sync2_reg[1];
   assign strobe_rise = sync2_reg[0] & ~sync3_reg[0];

   // ==========================================================
   // Shift register and control registers
   logic [WORD_W-1:0] shift_reg, shift_next;
   logic [WORD_W-1:0] ctrl_reg [NUM_REGS];
   logic [WORD_W-1:0] ctrl_next [NUM_REGS];
   always_comb begin
      shift_next = shift_reg;
      if (sck_rise) begin
         shift_next = {shift_reg[WORD_W-2:0], sdata};
      end
   end
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_ctrl
         always_comb begin
            ctrl_next[g] = ctrl_reg[g];
            if (strobe_rise && shift_reg[CTRL_W-1:0] == CTRL_W'(g)) begin
               ctrl_next[g] = shift_reg;
            end
         end
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               ctrl_reg[g] <= WORD_RESET;
            end else begin
               ctrl_reg[g] <= ctrl_next[g];
            end
         end
      end
   endgenerate
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift_reg <= WORD_RESET;
      end else begin
         shift_reg <= shift_next;
      end
   end

   // ==========================================================
   // Decoded control outputs
   logic [WORD_W-1:0] c1, c2, cm;
   assign c1 = ctrl_reg[SEL_FIRST];
   assign c2 = ctrl_reg[SEL_SECOND];
   assign cm = ctrl_reg[SEL_MUX];
   logic [MUX_W-1:0] mux_sel;
   assign mux_sel = cm[F_MUX_LO +: MUX_W];
   assign shift_word = shift_reg;
   assign prescale_128_first = c1[F_PRESCALE];
   assign prescale_128_second = c2[F_PRESCALE];
   assign pwdn_first = c1[F_PWDN];
   assign pwdn_second = c2[F_PWDN];
   assign pwdn_async = cm[F_PWDN_MODE];
   assign pump_tri = cm[F_PUMP_TRI];
   assign pump_hi_cur_first = c1[F_PUMP_CUR];
   assign pump_hi_cur_second = c2[F_PUMP_CUR];
   // The second synthesizer word has no fast-acquisition field.
   assign fast_acq_first = c1[F_FAST];

   // ==========================================================
   // Multiplexed status pin
   logic mux_out_next, mux_oe_next, mux_out_reg, mux_oe_reg;
   always_comb begin
      mux_oe_next = 1'b1;
      mux_out_next = 1'b0;
      unique case (mux_sel)
         MUX_TRI: mux_oe_next = 1'b0;
         MUX_GP_LOW: mux_out_next = 1'b0;
         MUX_GP_HIGH: mux_out_next = 1'b1;
         MUX_LOCK_FIRST: mux_out_next = lock_first;
         MUX_LOCK_SECOND: mux_out_next = lock_second;
         MUX_REF_DIV: mux_out_next = ref_div_out;
         MUX_FB_DIV: mux_out_next = fb_div_out;
         MUX_FAST_SW: mux_out_next = fast_acq_first;
      endcase
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mux_out_reg <= 1'b0;
         mux_oe_reg <= 1'b0;
      end else begin
         mux_out_reg <= mux_out_next;
         mux_oe_reg <= mux_oe_next;
      end
   end
   assign mux_status_out = mux_out_reg;
   assign mux_status_oe = mux_oe_reg;

   // ==========================================================
   // Assertions
   property p_shift;
      @(posedge clk) disable iff (!rstn)
         sck_rise |=> shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(sdata)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");
   property p_hold;
      @(posedge clk) disable iff (!rstn)
         !sck_rise |=> $stable(shift_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("shift moved");
   // The first, second and mux registers each have their own load and guard check, so a decode slip onto a
   // neighbouring register is caught as well as a missed load.
   property p_load;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] == SEL_FIRST |=> c1 == $past(shift_reg);
   endproperty
   a_load: assert property (p_load) else $error("load missed");
   property p_load_second;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] == SEL_SECOND |=> c2 == $past(shift_reg);
   endproperty
   a_load_second: assert property (p_load_second) else $error("load2 missed");
   property p_load_mux;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] == SEL_MUX |=> cm == $past(shift_reg);
   endproperty
   a_load_mux: assert property (p_load_mux) else $error("mux load missed");
   property p_sel;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] != SEL_SECOND |=> $stable(c2);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong target");
   property p_sel_first;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] != SEL_FIRST |=> $stable(c1);
   endproperty
   a_sel_first: assert property (p_sel_first) else $error("first hit");
   property p_sel_mux;
      @(posedge clk) disable iff (!rstn)
         strobe_rise && shift_reg[1:0] != SEL_MUX |=> $stable(cm);
   endproperty
   a_sel_mux: assert property (p_sel_mux) else $error("mux hit");
   property p_keep;
      @(posedge clk) disable iff (!rstn)
         !strobe_rise |=> $stable(c1) && $stable(cm);
   endproperty
   a_keep: assert property (p_keep) else $error("reg changed");
   property p_keep_second;
      @(posedge clk) disable iff (!rstn)
         !strobe_rise |=> $stable(c2);
   endproperty
   a_keep_second: assert property (p_keep_second) else $error("reg2 changed");
   property p_drive;
      @(posedge clk) disable iff (!rstn)
         mux_sel != MUX_TRI |=> mux_status_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("pin not driven");
   property p_gp_low;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_GP_LOW |=> !mux_status_out;
   endproperty
   a_gp_low: assert property (p_gp_low) else $error("low wrong");
   property p_gp_high;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_GP_HIGH |=> mux_status_out;
   endproperty
   a_gp_high: assert property (p_gp_high) else $error("high wrong");
   property p_lock_second;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_LOCK_SECOND |=> mux_status_out == $past(lock_second);
   endproperty
   a_lock_second: assert property (p_lock_second) else $error("lock2 wrong");
   property p_ref_div;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_REF_DIV |=> mux_status_out == $past(ref_div_out);
   endproperty
   a_ref_div: assert property (p_ref_div) else $error("ref wrong");
   property p_fb_div;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_FB_DIV |=> mux_status_out == $past(fb_div_out);
   endproperty
   a_fb_div: assert property (p_fb_div) else $error("fb wrong");
   property p_tri;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_TRI |=> !mux_status_oe;
   endproperty
   a_tri: assert property (p_tri) else $error("pin driven");
   property p_lock;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_LOCK_FIRST |=> mux_status_oe && mux_status_out == $past(lock_first);
   endproperty
   a_lock: assert property (p_lock) else $error("lock wrong");
   property p_fast;
      @(posedge clk) disable iff (!rstn)
         mux_sel == MUX_FAST_SW |=> mux_status_out == $past(fast_acq_first);
   endproperty
   a_fast: assert property (p_fast) else $error("fast wrong");
endmodule // synth_loader

// >>> test/host_serial_model.sv
// Purpose: Host side of the three-wire loader link.
// Assumes: The serial clock idles low between words.
// Notes: Each serial phase lasts 16 system clocks, 80 ns.
`timescale 1ns/10ps
module host_serial_model (
   input wire logic clk,
   output logic serial_clk,
   output logic serial_data,
   output logic load_strobe
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   task automatic half_bit();
      repeat (16) @(negedge clk);
   endtask
   // ==========================================================
   // Word transfer
   // Nothing holds the data line after a word, so it shows the inverse of the last bit.
   task automatic send_word(input logic [21:0] w, input logic load);
      for (int i = 21; i >= 0; i--) begin
         serial_data = w[i];
         half_bit();
         serial_clk = 1'b1;
         half_bit();
         serial_clk = 1'b0;
      end
      load_strobe = load;
      half_bit();
      load_strobe = 1'b0;
      serial_data = ~w[0];
   endtask
endmodule // host_serial_model

// >>> test/synth_loader_tb.sv
// Purpose: Self-checking bench for the serial control loader.
// Assumes: Host model drives the link; status sources come from the bench.
// Notes: Outputs are judged a few clocks after each word settles.
`timescale 1ns/10ps
module synth_loader_tb
   import synth_loader_pkg::*;
;
   logic clk, rstn, serial_clk, serial_data, load_strobe;
   logic lock_first, lock_second, ref_div_out, fb_div_out, mux_status_out, mux_status_oe;
   logic prescale_128_first, prescale_128_second, pwdn_first, pwdn_second, pwdn_async;
   logic pump_tri, pump_hi_cur_first, pump_hi_cur_second, fast_acq_first;
   logic [WORD_W-1:0] shift_word;
   int n_fail = 0;
   int n_compared = 0;
   synth_loader DUT (.clk(clk), .rstn(rstn), .serial_clk(serial_clk),
      .serial_data(serial_data), .load_strobe(load_strobe), .lock_first(lock_first),
      .lock_second(lock_second), .ref_div_out(ref_div_out), .fb_div_out(fb_div_out),
      .mux_status_out(mux_status_out), .mux_status_oe(mux_status_oe),
      .prescale_128_first(prescale_128_first), .prescale_128_second(prescale_128_second),
      .pwdn_first(pwdn_first), .pwdn_second(pwdn_second), .pwdn_async(pwdn_async),
      .pump_tri(pump_tri), .pump_hi_cur_first(pump_hi_cur_first),
      .pump_hi_cur_second(pump_hi_cur_second), .fast_acq_first(fast_acq_first),
      .shift_word(shift_word));
   host_serial_model host (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data),
      .load_strobe(load_strobe));
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [WORD_W-1:0] w, input logic ld);
      host.send_word(w, ld);
      repeat (8) @(negedge clk);
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk(shift_word, WORD_RESET);
      chk(22'({prescale_128_first, prescale_128_second, pwdn_first, pwdn_second}), 22'h0);
      chk(22'({pwdn_async, pump_tri, pump_hi_cur_first, pump_hi_cur_second}), 22'h0);
      chk(22'({fast_acq_first, mux_status_oe, mux_status_out}), 22'h0);
   endtask
   task automatic t_first();
      put(22'h0000cc, 1'b1);
      chk(shift_word, 22'h0000cc);
      chk(22'({prescale_128_first, pwdn_first, pump_hi_cur_first, fast_acq_first}), 22'hf);
      chk(22'({prescale_128_second, pwdn_second, pump_hi_cur_second}), 22'h0);
   endtask
   task automatic t_second();
      put(22'h0000c5, 1'b1);
      chk(22'({prescale_128_second, pwdn_second, pump_hi_cur_second}), 22'h5);
      chk(22'(fast_acq_first), 22'h1);
      chk(22'({prescale_128_first, pwdn_first}), 22'h3);
   endtask
   task automatic t_hold();
      put(22'h3fff01, 1'b0);
      chk(shift_word, 22'h3fff01);
      chk(22'({prescale_128_second, pwdn_second, pump_hi_cur_second}), 22'h5);
   endtask
   // Runs after the status scenario so the pin is seen to leave the driven state.
   task automatic t_mode();
      put(22'h000032, 1'b1);
      chk(22'(pwdn_async), 22'h1);
      chk(22'(pump_tri), 22'h1);
      chk(22'(mux_status_oe), 22'h0);
   endtask
   task automatic t_mux();
      logic [3:0] pins;
      logic e;
      for (int c = 1; c < 8; c++) begin
         pins = c[0] ? 4'ha : 4'h5;
         {lock_first, lock_second, ref_div_out, fb_div_out} = pins;
         put({11'h000, c[2:0], 8'h02}, 1'b1);
         case (c)
            1: e = 1'b0;
            2: e = 1'b1;
            3: e = pins[3];
            4: e = pins[2];
            5: e = pins[1];
            6: e = pins[0];
            // The fast switch follows the first word's fast bit, set earlier.
            default: e = 1'b1;
         endcase
         chk(22'(mux_status_oe), 22'h1);
         chk(22'(mux_status_out), {21'h0, e});
      end
      chk(22'({pwdn_async, pump_tri}), 22'h0);
   endtask
   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      {lock_first, lock_second, ref_div_out, fb_div_out} = 4'h0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_first();
      t_second();
      t_hold();
      t_mux();
      t_mode();
      report_and_stop();
   end
   // Eleven words take about 40 us, so 200 us only trips on a hang.
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule // synth_loader_tb
